/* dv/cdt_decode_properties.sv */
// checker for cdt_decode: handshake, address and refusal relations
// assumes a bind into cdt_decode, one clock clk_sys and reset arst_n
module cdt_decode_chk
    import cdt_pkg::*;
#(
    parameter int NUM_INSTR = 55
)
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        arst_n,
    // instruction side
    input wire logic        ins_valid,
    input wire logic        ins_ready,
    input wire cdt_instr_s  ins,
    input wire logic [15:0] rf_a_data,
    input wire cdt_rfw_s    rf_wr,
    input wire cdt_rfw_s    rf_ptr_wr,
    // memory and results
    input wire cdt_mreq_s   mem,
    input wire logic        mem_ack,
    input wire logic [15:0] mem_rdata,
    input wire cdt_disp_s   disp,
    input wire cdt_br_s     br,
    input wire logic        undef
);
    logic take;
    logic mv_take;
    assign take    = ins_valid && ins_ready;
    assign mv_take = take && ins.op == op_general_move && ins.stk == stk_none;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_push; take && ins.stk == stk_push; endsequence
    sequence s_pop; take && ins.stk == stk_pop; endsequence
    sequence s_rd_ack; mem.req && mem_ack && !mem.we && mem.word; endsequence

    chk_busy_ready: assert property (mem.req |-> !ins_ready)
        else $error("ready high during access");
    chk_req_hold: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr) && $stable(mem.wdata))
        else $error("request changed before ack");
    chk_word_even: assert property (mem.req && mem.word |-> !mem.addr[0])
        else $error("odd word address");
    chk_ind_page: assert property (take && ins.mode == memory_indirect_mode && ins.op == op_jump
        |=> mem.req && mem.word && mem.addr == {IND_PAGE, $past(ins.abs8) & 8'hfe}) else $error("pointer address");
    chk_read_result: assert property (s_rd_ack |=> (rf_wr.we && rf_wr.data == $past(mem_rdata))
        || (br.valid && br.target == $past(mem_rdata))) else $error("read result lost");
    chk_push_issue: assert property (s_push |=> mem.req && mem.we && rf_ptr_wr.we
        && rf_ptr_wr.data == $past(rf_a_data) - STEP_WORD) else $error("push step");
    chk_pop_issue: assert property (s_pop |=> mem.req && !mem.we && mem.word
        && mem.addr == ($past(rf_a_data) & 16'hfffe) && rf_ptr_wr.data == $past(rf_a_data) + STEP_WORD)
        else $error("pop step");
    chk_short_word: assert property (mv_take && ins.word && ins.mode == short_absolute_mode
        |=> undef && !mem.req) else $error("word short absolute accepted");
    chk_byte_stack: assert property (mv_take && !ins.word && ins.rp == SP_IDX
        && (ins.mode == predecrement_mode || ins.mode == postincrement_mode) |=> undef) else $error("byte stack move");
    chk_op_limit: assert property (take && ins.op >= 6'(NUM_INSTR) |=> undef && !disp.valid)
        else $error("illegal op accepted");
    chk_cond_field: assert property (take && ins.op == op_cond_branch
        |=> disp.valid && disp.grp == grp_branch && disp.cond == $past(ins.cond)) else $error("condition lost");
endmodule

bind cdt_decode cdt_decode_chk #(.NUM_INSTR(NUM_INSTR)) u_chk (
    .clk_sys(clk_sys), .arst_n(arst_n), .ins_valid(ins_valid), .ins_ready(ins_ready), .ins(ins),
    .rf_a_data(rf_a_data), .rf_wr(rf_wr), .rf_ptr_wr(rf_ptr_wr), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .disp(disp), .br(br), .undef(undef)
);

/* dv/cdt_decode_tb_top.sv */
// testbench for cdt_decode with the memory and register file model
// assumes register k resets to 0x0041 + 0x100*k and memory word j to 0xa500 + j
module cdt_decode_tb_top
    import cdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        arst_n = 1'b0;
    logic        ins_valid = 1'b0;
    cdt_instr_s  ins = '0;
    logic [3:0]  lat = 4'h1;
    logic        ins_ready, rf_b_word, mem_ack, undef;
    logic [2:0]  rf_a_idx;
    logic [3:0]  rf_b_idx;
    logic [15:0] rf_a_data, rf_b_data, mem_rdata, d;
    cdt_rfw_s    rf_wr, rf_ptr_wr;
    cdt_mreq_s   mem;
    cdt_disp_s   disp;
    cdt_br_s     br;
    cdt_instr_s  i;
    int          errors = 0;
    int          compares = 0;

    cdt_decode #(.NUM_INSTR(55)) DUT (.clk_sys(clk_sys), .arst_n(arst_n), .ins_valid(ins_valid),
        .ins_ready(ins_ready), .ins(ins), .rf_a_idx(rf_a_idx), .rf_a_data(rf_a_data), .rf_b_idx(rf_b_idx),
        .rf_b_word(rf_b_word), .rf_b_data(rf_b_data), .rf_wr(rf_wr), .rf_ptr_wr(rf_ptr_wr), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .disp(disp), .br(br), .undef(undef));
    cdt_mem_model u_model (.clk_sys(clk_sys), .arst_n(arst_n), .lat(lat), .rf_a_idx(rf_a_idx),
        .rf_a_data(rf_a_data), .rf_b_idx(rf_b_idx), .rf_b_word(rf_b_word), .rf_b_data(rf_b_data),
        .rf_wr(rf_wr), .rf_ptr_wr(rf_ptr_wr), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // waits until idle, offers one instruction, returns just after the taking edge
    task automatic issue(input cdt_instr_s x);
        for (int n = 0; ins_ready !== 1'b1; n++) begin
            if (n > 60) begin errors++; give_verdict(); end
            @(posedge clk_sys); #1;
        end
        @(posedge clk_sys);
        ins_valid <= 1'b1;
        ins <= x;
        @(posedge clk_sys);
        ins_valid <= 1'b0;
        #1;
    endtask
    task automatic await(input logic sel_br, output logic [15:0] v);
        for (int n = 0; (sel_br ? br.valid : rf_wr.we) !== 1'b1; n++) begin
            if (n > 60) begin errors++; give_verdict(); end
            @(posedge clk_sys); #1;
        end
        v = sel_br ? br.target : rf_wr.data;
    endtask
    function automatic cdt_instr_s mv(logic w, cdt_mode_e m, logic ld, logic [2:0] p);
        cdt_instr_s x;
        x = '0;
        x.op = op_general_move; x.word = w; x.mode = m; x.load = ld; x.rp = p;
        x.rd = 4'h4; x.rs = 4'h2; x.ext = 16'hbeef; x.abs8 = 8'h20;
        return x;
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_moves();
        cdt_mode_e   md [3] = '{mode_reg_indirect, mode_disp16, mode_abs16};
        logic [15:0] ea [3] = '{16'h0140, 16'hc030, 16'hbeee};
        issue(mv(1'b1, mode_reg_direct, 1'b1, 3'h0));
        check("reg move data", rf_wr.data, 16'h0241);
        issue(mv(1'b0, mode_reg_direct, 1'b1, 3'h0));
        check("byte move data", rf_wr.data, 16'h0041);
        check("byte move size", 16'(rf_wr.word), 16'h0000);
        issue(mv(1'b1, mode_imm, 1'b1, 3'h0));
        check("imm move data", rf_wr.data, 16'hbeef);
        check("imm move idx", 16'(rf_wr.idx), 16'h0004);
        for (int k = 0; k < 3; k++) begin
            issue(mv(1'b1, md[k], 1'b0, 3'h1));
            check("word store addr", mem.addr, ea[k]);
            check("word store data", mem.wdata, 16'hbeef);
        end
    endtask
    task automatic t_refuse();
        logic        w [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        logic        ld [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        logic [2:0]  p [5] = '{3'h0, 3'h7, 3'h7, 3'h0, 3'h0};
        cdt_mode_e   m [5] = '{short_absolute_mode, predecrement_mode, postincrement_mode, mode_reg_direct, mode_pc_rel};
        for (int k = 0; k < 5; k++) begin
            i = mv(w[k], m[k], ld[k], p[k]);
            if (k == 3) i.op = OP_LIMIT;
            issue(i);
            check("refused undef", 16'(undef), 16'h0001);
            check("refused req", 16'(mem.req), 16'h0000);
        end
    endtask
    task automatic t_bytes();
        issue(mv(1'b0, short_absolute_mode, 1'b0, 3'h0));
        check("short abs addr", mem.addr, 16'hff20);
        issue(mv(1'b0, predecrement_mode, 1'b0, 3'h2));
        check("byte predec addr", mem.addr, 16'h0240);
        check("byte predec ptr", rf_ptr_wr.data, 16'h0240);
    endtask
    task automatic t_stack();
        @(posedge clk_sys);
        lat <= 4'h4;
        i = '0;
        i.stk = stk_push;
        i.rd = 4'h3;
        issue(i);
        check("push addr", mem.addr, 16'h073e);
        check("push data", mem.wdata, 16'h0341);
        check("push ptr", rf_ptr_wr.data, 16'h073f);
        check("push ptr idx", 16'(rf_ptr_wr.idx), 16'h0007);
        i.stk = stk_pop;
        i.rd = 4'h5;
        issue(i);
        check("pop addr", mem.addr, 16'h073e);
        check("pop ptr", rf_ptr_wr.data, 16'h0741);
        await(1'b0, d);
        check("pop data", d, 16'h0341);
        check("pop idx", 16'(rf_wr.idx), 16'h0005);
    endtask
    task automatic t_dispatch();
        int lim [8] = '{1, 15, 19, 27, 41, 46, 54, 55};
        int g;
        for (int op = 1; op < 55; op++) begin
            g = 0;
            while (op >= lim[g]) g++;
            i = '0;
            i.op = 6'(op);
            i.cond = 4'(op);
            issue(i);
            check("disp group", 16'(disp.grp), 16'(g));
            check("disp op", 16'(disp.op), 16'(op));
            if (i.op == op_cond_branch) check("disp cond", 16'(disp.cond), 16'(i.cond));
        end
    endtask
    task automatic t_indirect();
        for (int k = 0; k < 2; k++) begin
            i = '0;
            i.op = (k == 0) ? 6'(op_jump) : 6'(op_jump_sub);
            i.mode = memory_indirect_mode;
            i.abs8 = (k == 0) ? 8'h13 : 8'h20;
            issue(i);
            check("pointer addr", mem.addr, (k == 0) ? 16'h0012 : 16'h0020);
            check("pointer size", 16'(mem.word), 16'h0001);
            await(1'b1, d);
            check("branch target", d, (k == 0) ? 16'ha509 : 16'ha510);
        end
    endtask

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_moves();
        t_refuse();
        t_bytes();
        t_stack();
        t_dispatch();
        t_indirect();
        give_verdict();
    end
endmodule

/* dv/cdt_mem_model.sv */
// model of the memory bus and general register file beside cdt_decode
// assumes one request at a time; ack comes lat cycles after req rises
module cdt_mem_model
    import cdt_pkg::*;
(
    // clock, reset, latency
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic [3:0]  lat,
    // register file
    input  wire logic [2:0]  rf_a_idx,
    output logic [15:0]      rf_a_data,
    input  wire logic [3:0]  rf_b_idx,
    input  wire logic        rf_b_word,
    output logic [15:0]      rf_b_data,
    input  wire cdt_rfw_s    rf_wr,
    input  wire cdt_rfw_s    rf_ptr_wr,
    // memory bus
    input  wire cdt_mreq_s   mem,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata
);
    logic [15:0] regs [8];
    logic [15:0] words [256];
    logic [3:0]  wait_q;
    assign rf_a_data = regs[rf_a_idx];
    assign rf_b_data = rf_b_word ? regs[rf_b_idx[2:0]] : {8'h00, regs[rf_b_idx[2:0]][7:0]};
    assign mem_ack   = mem.req && wait_q == lat;
    // outside the ack cycle the read bus shows the inverse, never a stale match
    assign mem_rdata = mem_ack ? words[mem.addr[8:1]] : ~words[mem.addr[8:1]];
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wait_q <= 4'h0;
            for (int k = 0; k < 8; k++)
                regs[k] <= 16'h0041 + 16'h0100 * 16'(k);
            for (int j = 0; j < 256; j++)
                words[j] <= {8'ha5, 8'(j)};
        end else begin
            wait_q <= (mem.req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
            if (mem_ack && mem.we)
                words[mem.addr[8:1]] <= mem.wdata;
            if (rf_ptr_wr.we)
                regs[rf_ptr_wr.idx[2:0]] <= rf_ptr_wr.data;
            if (rf_wr.we)
                regs[rf_wr.idx[2:0]] <= rf_wr.data;
        end
    end
endmodule

/* hw/cdt_decode.sv */
// data-transfer decode and execute: classifies all instructions, runs moves, push, pop
// and memory-indirect target fetch; assumes a combinational register file read and a
// memory bus that holds mem_ack high for one cycle per accepted request
//
// Overview of operation
// RL1: memory-indirect jumps read a 16-bit target from address zero-page byte given by the instruction.
// RL2: exactly 55 instructions are recognised and sorted into eight functional groups.
// RL3: push is a word move of the register to memory with pre-decrement of the stack pointer.
// RL4: pop is a word move from memory to the register with post-increment of the stack pointer.
// RL5: the move copies register to register, register to memory, memory to register or immediate to register.
// RL6: word moves accept direct, indirect, displacement, 16-bit absolute, immediate, pre-decrement and post-increment.
// RL7: the short absolute mode is accepted by the move only for byte size.
// RL8: pre-decrement and post-increment through the stack pointer are word size only.
// RL9: all conditional branches are one instruction that carries its condition field.
// RL10: post-increment and pre-decrement step the pointer by one for bytes and two for words and keep the result.
// RL11: word accesses at odd addresses clear the low address bit.
// RL12: a word move in the short absolute mode is reported as undefined and not executed.
module cdt_decode
    import cdt_pkg::*;
#(
    parameter int NUM_INSTR = 55
)
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    // instruction in
    input  wire logic       ins_valid,
    output logic            ins_ready,
    input  wire cdt_instr_s ins,
    // register file read
    output logic [2:0]      rf_a_idx,
    input  wire logic [15:0] rf_a_data,
    output logic [3:0]      rf_b_idx,
    output logic            rf_b_word,
    input  wire logic [15:0] rf_b_data,
    // register file write
    output cdt_rfw_s        rf_wr,
    output cdt_rfw_s        rf_ptr_wr,
    // memory bus
    output cdt_mreq_s       mem,
    input  wire logic       mem_ack,
    input  wire logic [15:0] mem_rdata,
    // results
    output cdt_disp_s       disp,
    output cdt_br_s         br,
    output logic            undef
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_INSTR != OP_COUNT) begin : g_chk
        $error("instruction count parameter must match the opcode set");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        st_idle, st_data, st_ind
    } cdt_st_e;

    typedef struct packed {
        cdt_st_e    st;
        cdt_mreq_s  mreq;
        cdt_rfw_s   rfw;
        cdt_rfw_s   rfp;
        cdt_disp_s  disp;
        cdt_br_s    br;
        logic       undef;
        logic [3:0] ld_rd;
    } cdt_state_s;

    cdt_state_s s_q;
    cdt_state_s s_d;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic cdt_grp_e grp_of(input logic [5:0] code);
        cdt_grp_e g;
        g = grp_none;
        if (code < OP_LIMIT) begin                                // RL2
            if (code <= 6'(op_general_move))
                g = grp_transfer;
            else if (code <= 6'(op_neg))
                g = grp_arith;
            else if (code <= 6'(op_not))
                g = grp_logic;
            else if (code <= 6'(op_rotc_r))
                g = grp_shift;
            else if (code <= 6'(op_bit_ist))
                g = grp_bit;
            else if (code <= 6'(op_ret_sub))
                g = grp_branch;
            else if (code <= 6'(op_nop))
                g = grp_sysctl;
            else
                g = grp_block;
        end
        return g;
    endfunction

    function automatic logic move_legal(input cdt_instr_s i);
        logic ok;
        ok = 1'b1;
        unique case (i.mode)
            mode_pc_rel, memory_indirect_mode: ok = 1'b0;
            short_absolute_mode: ok = !i.word;                    // RL7 RL12
            mode_imm:            ok = i.load;                     // RL6
            postincrement_mode:  ok = i.load && (i.word || i.rp != SP_IDX);   // RL8
            predecrement_mode:   ok = !i.load && (i.word || i.rp != SP_IDX);  // RL8
            default:             ok = 1'b1;
        endcase
        return ok;
    endfunction

    // ------------------------------------------------------------
    // stack forms become word moves through the stack pointer
    // ------------------------------------------------------------
    cdt_instr_s  mi;
    cdt_grp_e    grp;
    logic [15:0] ea_addr;
    logic [15:0] ea_ptr;
    logic        ea_upd;

    always_comb begin
        mi = ins;
        if (ins.stk == stk_push) begin                            // RL3
            mi.word = 1'b1;
            mi.mode = predecrement_mode;
            mi.load = 1'b0;
            mi.rp   = SP_IDX;
        end else if (ins.stk == stk_pop) begin                    // RL4
            mi.word = 1'b1;
            mi.mode = postincrement_mode;
            mi.load = 1'b1;
            mi.rp   = SP_IDX;
        end
    end

    assign grp       = grp_of(ins.op);
    assign ins_ready = (s_q.st == st_idle);
    assign rf_a_idx  = mi.rp;
    assign rf_b_idx  = (mi.mode == mode_reg_direct) ? mi.rs : mi.rd;
    assign rf_b_word = mi.word;

    cdt_ea_unit u_ea (
        .mode     (mi.mode),
        .word     (mi.word),
        .base     (rf_a_data),
        .ext      (mi.ext),
        .abs8     (mi.abs8),
        .addr     (ea_addr),
        .ptr_next (ea_ptr),
        .ptr_upd  (ea_upd)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d             = s_q;
        s_d.rfw.we      = 1'b0;
        s_d.rfp.we      = 1'b0;
        s_d.disp.valid  = 1'b0;
        s_d.br.valid    = 1'b0;
        s_d.undef       = 1'b0;
        unique case (s_q.st)
            st_idle: begin
                if (ins_valid) begin
                    if (grp == grp_none) begin
                        s_d.undef = 1'b1;
                    end else if (ins.op == 6'(op_general_move)) begin
                        if (!move_legal(mi)) begin
                            s_d.undef = 1'b1;                     // RL12
                        end else if (mi.mode == mode_reg_direct || mi.mode == mode_imm) begin
                            s_d.rfw.we   = 1'b1;                  // RL5
                            s_d.rfw.word = mi.word;
                            s_d.rfw.idx  = mi.rd;
                            if (mi.mode == mode_imm)
                                s_d.rfw.data = mi.word ? mi.ext : {8'h00, mi.ext[7:0]};
                            else
                                s_d.rfw.data = mi.word ? rf_b_data : {8'h00, rf_b_data[7:0]};
                        end else begin
                            s_d.mreq.req   = 1'b1;                // RL5
                            s_d.mreq.we    = !mi.load;
                            s_d.mreq.word  = mi.word;
                            s_d.mreq.addr  = ea_addr;             // RL11
                            s_d.mreq.wdata = mi.word ? rf_b_data : {8'h00, rf_b_data[7:0]};
                            s_d.ld_rd      = mi.rd;
                            s_d.rfp.we     = ea_upd;              // RL10
                            s_d.rfp.word   = 1'b1;
                            s_d.rfp.idx    = {1'b0, mi.rp};
                            s_d.rfp.data   = ea_ptr;
                            s_d.st         = st_data;
                        end
                    end else if ((ins.op == 6'(op_jump) || ins.op == 6'(op_jump_sub))
                                 && ins.mode == memory_indirect_mode) begin
                        s_d.mreq.req   = 1'b1;                    // RL1
                        s_d.mreq.we    = 1'b0;
                        s_d.mreq.word  = 1'b1;
                        // the pointer fetch is a word read whatever size the instruction carries
                        s_d.mreq.addr  = {ea_addr[15:1], 1'b0};    // RL11
                        s_d.mreq.wdata = 16'h0000;
                        s_d.st         = st_ind;
                    end else begin
                        s_d.disp.valid = 1'b1;                    // RL2
                        s_d.disp.grp   = grp;
                        s_d.disp.op    = ins.op;
                        s_d.disp.cond  = ins.cond;                // RL9
                    end
                end
            end
            st_data: begin
                if (mem_ack) begin
                    s_d.mreq.req = 1'b0;
                    if (!s_q.mreq.we) begin
                        s_d.rfw.we   = 1'b1;                      // RL4
                        s_d.rfw.word = s_q.mreq.word;
                        s_d.rfw.idx  = s_q.ld_rd;
                        s_d.rfw.data = s_q.mreq.word ? mem_rdata : {8'h00, mem_rdata[7:0]};
                    end
                    s_d.st = st_idle;
                end
            end
            st_ind: begin
                if (mem_ack) begin
                    s_d.mreq.req  = 1'b0;
                    s_d.br.valid  = 1'b1;                         // RL1
                    s_d.br.target = mem_rdata;
                    s_d.st        = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mem       = s_q.mreq;
    assign rf_wr     = s_q.rfw;
    assign rf_ptr_wr = s_q.rfp;
    assign disp      = s_q.disp;
    assign br        = s_q.br;
    assign undef     = s_q.undef;

endmodule

/* hw/cdt_ea_unit.sv */
// effective address unit: operand address, aligned address and pointer update
// assumes base is the 16-bit pointer register value read in the same cycle
module cdt_ea_unit
    import cdt_pkg::*;
(
    // operand description
    input  wire cdt_mode_e   mode,
    input  wire logic        word,
    input  wire logic [15:0] base,
    input  wire logic [15:0] ext,
    input  wire logic [7:0]  abs8,
    // results
    output logic [15:0]      addr,
    output logic [15:0]      ptr_next,
    output logic             ptr_upd
);

    logic [15:0] step;
    logic [15:0] raw;

    assign step = word ? STEP_WORD : STEP_BYTE;                   // RL10

    always_comb begin
        raw      = RST_ADDR;
        ptr_next = base;
        ptr_upd  = 1'b0;
        unique case (mode)
            mode_reg_indirect:    raw = base;
            mode_disp16:          raw = base + ext;
            postincrement_mode: begin
                raw      = base;
                ptr_next = base + step;                           // RL10
                ptr_upd  = 1'b1;
            end
            predecrement_mode: begin
                raw      = base - step;                           // RL10
                ptr_next = base - step;
                ptr_upd  = 1'b1;
            end
            short_absolute_mode:  raw = {SHORT_PAGE, abs8};
            mode_abs16:           raw = ext;
            memory_indirect_mode: raw = {IND_PAGE, abs8};         // RL1
            default:              raw = RST_ADDR;
        endcase
    end

    // word accesses drop the low address bit
    assign addr = word ? {raw[15:1], 1'b0} : raw;                 // RL11

endmodule

/* hw/cdt_pkg.sv */
// package for the data-transfer decode block: opcode set, groups, modes and carriers
// assumes a 16-bit address space and a general register file of eight 16-bit registers
package cdt_pkg;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 16;
    localparam int          OP_COUNT       = 55;
    localparam logic [5:0]  OP_LIMIT       = 6'h37;
    localparam logic [7:0]  IND_PAGE       = 8'h00;
    localparam logic [7:0]  SHORT_PAGE     = 8'hff;
    localparam logic [2:0]  SP_IDX         = 3'h7;
    localparam logic [15:0] STEP_BYTE      = 16'h0001;
    localparam logic [15:0] STEP_WORD      = 16'h0002;
    localparam logic [15:0] RST_ADDR       = 16'h0000;

    // ------------------------------------------------------------
    // instruction set, in group order
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        op_general_move,
        op_add, op_sub, op_add_carry, op_sub_carry, op_inc, op_dec, op_add_step,
        op_sub_step, op_dec_adj_add, op_dec_adj_sub, op_mul_u, op_div_u, op_cmp, op_neg,
        op_and, op_or, op_xor, op_not,
        op_sha_l, op_sha_r, op_shl_l, op_shl_r, op_rot_l, op_rot_r, op_rotc_l, op_rotc_r,
        op_bit_set, op_bit_clr, op_bit_not, op_bit_tst, op_bit_and, op_bit_iand, op_bit_or,
        op_bit_ior, op_bit_xor, op_bit_ixor, op_bit_ld, op_bit_ild, op_bit_st, op_bit_ist,
        op_cond_branch, op_jump, op_branch_sub, op_jump_sub, op_ret_sub,
        op_ret_exc, op_sleep, op_ld_ctl, op_st_ctl, op_and_ctl, op_or_ctl, op_xor_ctl, op_nop,
        op_block_copy_instruction
    } cdt_op_e;

    typedef enum logic [3:0] {
        grp_transfer, grp_arith, grp_logic, grp_shift, grp_bit,
        grp_branch, grp_sysctl, grp_block, grp_none
    } cdt_grp_e;

    typedef enum logic [3:0] {
        mode_reg_direct, mode_reg_indirect, mode_disp16, postincrement_mode,
        predecrement_mode, short_absolute_mode, mode_abs16, mode_imm,
        mode_pc_rel, memory_indirect_mode
    } cdt_mode_e;

    typedef enum logic [1:0] {
        stk_none, stk_push, stk_pop
    } cdt_stk_e;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0]  op;
        cdt_stk_e    stk;
        logic        word;
        cdt_mode_e   mode;
        logic        load;
        logic [3:0]  rd;
        logic [3:0]  rs;
        logic [2:0]  rp;
        logic [15:0] ext;
        logic [7:0]  abs8;
        logic [3:0]  cond;
    } cdt_instr_s;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cdt_mreq_s;

    typedef struct packed {
        logic        we;
        logic        word;
        logic [3:0]  idx;
        logic [15:0] data;
    } cdt_rfw_s;

    typedef struct packed {
        logic        valid;
        cdt_grp_e    grp;
        logic [5:0]  op;
        logic [3:0]  cond;
    } cdt_disp_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] target;
    } cdt_br_s;

endpackage
